/* design/pscfg_defines.vh */
// shared constants for the strap and configuration pin block
`ifndef PSCFG_DEFINES_VH
`define PSCFG_DEFINES_VH
`define PSCFG_ADDR_BITS 2
`define PSCFG_ADDR3_IDX 0
`define PSCFG_ADDR4_IDX 1
`define PSCFG_ZERO1 1'h0
`define PSCFG_ONE1 1'h1
`define PSCFG_ZERO2 2'h0
`define PSCFG_MODE_HW 1'h0
`define PSCFG_MODE_SW 1'h1
`endif

/* design/pscfg_strap_latch.v */
// two-bit strap capture register loaded once after reset release
`timescale 1ns/1ps
`include "pscfg_defines.vh"
module pscfg_strap_latch (
    input wire clk_in, // reference clock
    input wire resetn_in, // async reset, active low
    input wire load_in, // one-cycle capture strobe
    input wire [`PSCFG_ADDR_BITS-1:0] data_in, // sampled strap levels
    output reg [`PSCFG_ADDR_BITS-1:0] data_out // held address bits
);
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_out <= `PSCFG_ZERO2;
        end else if (load_in) begin
            data_out <= data_in;
        end
    end
endmodule // pscfg_strap_latch

/* design/pscfg_pins.v */
// strap, led and configuration pin logic of the phy
// Summary of operation
// - address 3/4 pins are inputs during reset
// - sampled low gives zero, high gives one
// - address 3 pin drives transmit activity after reset
// - address 4 pin drives receive activity after reset
// - hardware mode: speed pin input, high=100
// - software mode: speed pin shows current speed
// - hardware mode: autoneg pin input, high=enabled
// - software mode: autoneg pin shows autoneg state
// - auto-crossover enable reads high when open
// - mode select low=hardware, high=software
`timescale 1ns/1ps
`include "pscfg_defines.vh"
module pscfg_pins (
    input wire clk_in, // reference clock, 50 mhz
    input wire resetn_in, // async reset, active low
    input wire addr3_tx_led_pin_in, // address 3 pin level
    input wire addr4_rx_led_pin_in, // address 4 pin level
    input wire tx_activity_in, // core transmit activity
    input wire rx_activity_in, // core receive activity
    input wire hardware_software_mode_select_in, // low hw, high sw
    input wire speed_select_pin_in, // speed pin level
    input wire autoneg_select_pin_in, // autoneg pin level
    input wire auto_crossover_enable_pin_in, // board level, pulled up
    input wire auto_crossover_pin_driven_in, // high when board drives it
    input wire sw_speed_100_in, // software speed setting
    input wire sw_autoneg_en_in, // software autoneg setting
    output reg addr3_tx_led_pin_out, // address 3 pin drive value
    output reg addr3_tx_led_pin_oe_out, // address 3 pin enable
    output reg addr4_rx_led_pin_out, // address 4 pin drive value
    output reg addr4_rx_led_pin_oe_out, // address 4 pin enable
    output reg speed_select_pin_out, // speed pin drive value
    output reg speed_select_pin_oe_out, // speed pin enable
    output reg autoneg_select_pin_out, // autoneg pin drive value
    output reg autoneg_select_pin_oe_out, // autoneg pin enable
    output reg [`PSCFG_ADDR_BITS-1:0] phy_addr_hi_out, // address bits 4:3
    output reg addr_valid_out, // straps captured
    output reg speed_100_out, // effective speed, high 100
    output reg autoneg_en_out, // effective autoneg enable
    output reg auto_crossover_en_out, // effective crossover enable
    output reg software_mode_out // current mode, high software
);
    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    reg captured;
    reg load;
    wire [`PSCFG_ADDR_BITS-1:0] strap_levels;
    wire [`PSCFG_ADDR_BITS-1:0] held_addr;
    wire next_load;

    // pins are only sampled, never driven, before capture
    assign strap_levels = {addr4_rx_led_pin_in, addr3_tx_led_pin_in};
    assign next_load = ~captured & ~load;

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            load <= `PSCFG_ZERO1;
            captured <= `PSCFG_ZERO1;
        end else begin
            load <= next_load;
            if (load) begin
                captured <= `PSCFG_ONE1;
            end
        end
    end

    pscfg_strap_latch u_latch (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .load_in(load),
        .data_in(strap_levels),
        .data_out(held_addr)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire sw_mode;
    wire xover_level;

    assign sw_mode = (hardware_software_mode_select_in == `PSCFG_MODE_SW);
    // an undriven pin reads as the pull-up level
    assign xover_level = auto_crossover_pin_driven_in ?
        auto_crossover_enable_pin_in : `PSCFG_ONE1;

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr3_tx_led_pin_out <= `PSCFG_ZERO1;
            addr3_tx_led_pin_oe_out <= `PSCFG_ZERO1;
            addr4_rx_led_pin_out <= `PSCFG_ZERO1;
            addr4_rx_led_pin_oe_out <= `PSCFG_ZERO1;
            speed_select_pin_out <= `PSCFG_ZERO1;
            speed_select_pin_oe_out <= `PSCFG_ZERO1;
            autoneg_select_pin_out <= `PSCFG_ZERO1;
            autoneg_select_pin_oe_out <= `PSCFG_ZERO1;
            phy_addr_hi_out <= `PSCFG_ZERO2;
            addr_valid_out <= `PSCFG_ZERO1;
            speed_100_out <= `PSCFG_ZERO1;
            autoneg_en_out <= `PSCFG_ZERO1;
            auto_crossover_en_out <= `PSCFG_ONE1;
            software_mode_out <= `PSCFG_ZERO1;
        end else begin
            // led drivers wait until the straps are held
            addr3_tx_led_pin_oe_out <= captured;
            addr3_tx_led_pin_out <= captured & tx_activity_in;
            addr4_rx_led_pin_oe_out <= captured;
            addr4_rx_led_pin_out <= captured & rx_activity_in;
            phy_addr_hi_out <= held_addr;
            addr_valid_out <= captured;
            software_mode_out <= sw_mode;
            speed_select_pin_oe_out <= sw_mode;
            autoneg_select_pin_oe_out <= sw_mode;
            speed_select_pin_out <= sw_mode & sw_speed_100_in;
            autoneg_select_pin_out <= sw_mode & sw_autoneg_en_in;
            if (sw_mode) begin
                speed_100_out <= sw_speed_100_in;
                autoneg_en_out <= sw_autoneg_en_in;
            end else begin
                speed_100_out <= speed_select_pin_in;
                autoneg_en_out <= autoneg_select_pin_in;
            end
            auto_crossover_en_out <= xover_level;
        end
    end
endmodule // pscfg_pins

/* tb/pscfg_pins_asserts.sv */
// assertions for the strap and configuration pin block
`timescale 1ns/1ps
module pscfg_pins_asserts (
    input wire clk_in, resetn_in, addr3_tx_led_pin_in, addr4_rx_led_pin_in, // pins
    input wire tx_activity_in, rx_activity_in, hardware_software_mode_select_in, // core
    input wire speed_select_pin_in, autoneg_select_pin_in, sw_speed_100_in, sw_autoneg_en_in,
    input wire addr3_tx_led_pin_out, addr4_rx_led_pin_out, addr3_tx_led_pin_oe_out, // leds
    input wire speed_select_pin_oe_out, speed_100_out, autoneg_en_out, addr_valid_out, // cfg
    input wire [1:0] phy_addr_hi_out // strapped bits
);
    reg r, m, s, a;
    always @(posedge clk_in) begin
        r <= resetn_in;
        m <= hardware_software_mode_select_in;
        s <= hardware_software_mode_select_in ? sw_speed_100_in : speed_select_pin_in;
        a <= hardware_software_mode_select_in ? sw_autoneg_en_in : autoneg_select_pin_in;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_rel; resetn_in && !$past(resetn_in); endsequence
    sequence s_cap; s_rel ##1 1; endsequence
    a_valid_timing: assert property (s_rel |-> !addr_valid_out [*3] ##1 addr_valid_out)
        else $error("capture timing");
    a_strap_value: assert property (s_cap |-> ##2
        phy_addr_hi_out == $past({addr4_rx_led_pin_in, addr3_tx_led_pin_in}, 2))
        else $error("strap value");
    a_addr_hold: assert property (addr_valid_out |=> $stable(phy_addr_hi_out))
        else $error("address moved");
    a_led_enable: assert property (addr3_tx_led_pin_oe_out == addr_valid_out)
        else $error("led enable");
    a_tx_led: assert property (r && addr_valid_out |-> addr3_tx_led_pin_out == $past(tx_activity_in))
        else $error("tx led");
    a_rx_led: assert property (r && addr_valid_out |-> addr4_rx_led_pin_out == $past(rx_activity_in))
        else $error("rx led");
    a_speed_eff: assert property (r |-> speed_100_out == s) else $error("speed");
    a_an_eff: assert property (r |-> autoneg_en_out == a) else $error("autoneg");
    a_pin_dir: assert property (r |-> speed_select_pin_oe_out == m) else $error("dir");
endmodule // pscfg_pins_asserts
bind pscfg_pins pscfg_pins_asserts u_chk (.*);

/* tb/pscfg_board.sv */
// board straps and pull resistors around the pin block
`timescale 1ns/1ps
module pscfg_board (
    input wire [3:0] oe_in, dout_in, lvl_in, // enables, drive values, resistor levels
    input wire xdrv_in, xlvl_in, // crossover pin drive and level
    output wire [3:0] pin_out, // resolved pins
    output wire xpin_out // resolved crossover pin
);
    assign pin_out = (oe_in & dout_in) | (~oe_in & lvl_in);
    assign xpin_out = xdrv_in ? xlvl_in : 1'b1;
endmodule // pscfg_board

/* tb/tb.sv */
// self-checking bench for the strap and configuration pin block
`timescale 1ns/1ps
module tb;
    reg clk_in = 0, resetn_in = 0, tx = 0, rx = 0, md = 0, spd = 0, an = 0, xd = 0, xl = 0;
    reg [3:0] lvl = 4'h0;
    wire [3:0] oe, dout, pin;
    wire xpin, xen, s100, anen, swm, vld;
    wire [1:0] addr;
    integer error_cnt = 0, n_compared = 0, i;
    pscfg_board u_brd (.oe_in(oe), .dout_in(dout), .lvl_in(lvl), .xdrv_in(xd), .xlvl_in(xl),
        .pin_out(pin), .xpin_out(xpin));
    pscfg_pins u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr3_tx_led_pin_in(pin[0]),
        .addr4_rx_led_pin_in(pin[1]), .tx_activity_in(tx), .rx_activity_in(rx),
        .hardware_software_mode_select_in(md), .speed_select_pin_in(pin[2]),
        .autoneg_select_pin_in(pin[3]), .auto_crossover_enable_pin_in(xpin),
        .auto_crossover_pin_driven_in(xd), .sw_speed_100_in(spd), .sw_autoneg_en_in(an),
        .addr3_tx_led_pin_out(dout[0]), .addr3_tx_led_pin_oe_out(oe[0]),
        .addr4_rx_led_pin_out(dout[1]), .addr4_rx_led_pin_oe_out(oe[1]),
        .speed_select_pin_out(dout[2]), .speed_select_pin_oe_out(oe[2]),
        .autoneg_select_pin_out(dout[3]), .autoneg_select_pin_oe_out(oe[3]),
        .phy_addr_hi_out(addr), .addr_valid_out(vld), .speed_100_out(s100),
        .autoneg_en_out(anen), .auto_crossover_en_out(xen), .software_mode_out(swm));
    task chk(input [3:0] got, input [3:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("FAIL %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task rst(input [1:0] s);
        begin
            resetn_in <= 1'b0;
            lvl <= {lvl[3:2], s};
            repeat (2) @(posedge clk_in);
            #1 chk(oe, 4'h0);
            chk({3'h0, xen}, 4'h1);
            @(posedge clk_in) resetn_in <= 1'b1;
            repeat (5) @(posedge clk_in);
            #1 chk({vld, 1'b0, addr}, {2'h2, s});
        end
    endtask
    initial forever #10 clk_in = ~clk_in;
    initial begin
        #20000 error_cnt = error_cnt + 1;
        $display("FAIL %0t watchdog expired", $time);
        summarize;
    end
    initial begin
        @(posedge clk_in) rst(2'h2);
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk_in) {rx, tx} <= i[1:0];
            repeat (2) @(posedge clk_in);
            #1 chk({dout[1:0], oe[1:0]}, {i[1:0], 2'h3});
        end
        for (i = 0; i < 16; i = i + 1) begin
            @(posedge clk_in) {md, an, spd} <= i[3:1];
            lvl[3:2] <= {2{i[0]}};
            repeat (2) @(posedge clk_in);
            #1 chk({oe[2], swm, s100, anen}, {i[3], i[3], i[3] ? {i[1], i[2]} : {2{i[0]}}});
            chk({pin[3:2], dout[3:2]}, i[3] ? {2{i[2], i[1]}} : {{2{i[0]}}, 2'h0});
        end
        #1 chk({3'h0, xen}, 4'h1);
        @(posedge clk_in) xd <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1 chk({3'h0, xen}, 4'h0);
        @(posedge clk_in) xl <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1 chk({3'h0, xen}, 4'h1);
        @(posedge clk_in) rst(2'h1);
        summarize;
    end
endmodule // tb
